// [dv/scs_host.sv]
// Pin-side host model: strap, config select, source select, references.
// Assumes the bench clock; pins move just after rising edges.
`timescale 1ns/100ps
`default_nettype none
module scs_host #(
  parameter int GAP = 40
) (
  input wire logic clk, // Clock
  input wire logic rst, // Reset
  input wire logic strap_req, // Wanted strap level
  input wire logic [1:0] sel_req, // Wanted config index
  input wire logic src_req, // Wanted source pin level
  output logic por_mode_strap, // Strap pin
  output logic cfg_select_low, // Select LSB pin
  output logic cfg_select_high, // Select MSB pin
  output logic input_source_pin, // Source select pin
  output logic crystal_ref_input, // Crystal level, period 8
  output logic diff_clock_input // Differential level, period 6
);
  int wait_cnt = 0;
  int ph = 0;
  initial begin
    {por_mode_strap, cfg_select_low, cfg_select_high} = 3'h0;
    {input_source_pin, crystal_ref_input, diff_clock_input} = 3'h0;
  end
  always @(posedge clk) begin
    ph <= (ph == 11) ? 0 : ph + 1;
    if (ph % 4 == 3) crystal_ref_input <= ~crystal_ref_input;
    if (ph % 3 == 2) diff_clock_input <= ~diff_clock_input;
    por_mode_strap <= strap_req;
    input_source_pin <= src_req;
    if (rst) begin
      {cfg_select_high, cfg_select_low} <= sel_req;
      wait_cnt <= GAP;
    end else if (wait_cnt != 0) begin
      wait_cnt <= wait_cnt - 1;
    end else if (cfg_select_low != sel_req[0]) begin
      cfg_select_low <= sel_req[0];
      wait_cnt <= GAP;
    end else if (cfg_select_high != sel_req[1]) begin
      cfg_select_high <= sel_req[1];
      wait_cnt <= GAP;
    end
  end
endmodule : scs_host
`default_nettype wire

// [dv/scs_tb_top.sv]
// Bench for the startup configuration and clock select block.
// Assumes scs_pkg, scs_top and the scs_host pin model compiled first.
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin n_fail++; \
  $display("BAD %0t got %0h want %0h", $time, a, b); end end
module scs_tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic strap_req = 1'b0;
  logic [1:0] sel_req = 2'h0;
  logic src_req = 1'b0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, er, strap, sel_lo, sel_hi, src_pin, xref, dref;
  logic ref_clk_out, div_sync, hw_select_mode, config_busy, ref_on_crystal;
  logic [3:0] div_out;
  logic [1:0] active_config;
  logic [5:0] crystal_cap_code;
  logic [6:0] xin_cap_half_pf, xout_cap_half_pf;
  int n_fail = 0;
  int checks = 0;
  int syncs = 0;
  always #5 clk = ~clk;
  scs_host #(.GAP(40)) HOST (.clk(clk), .rst(rst), .strap_req(strap_req),
    .sel_req(sel_req), .src_req(src_req), .por_mode_strap(strap),
    .cfg_select_low(sel_lo), .cfg_select_high(sel_hi),
    .input_source_pin(src_pin), .crystal_ref_input(xref),
    .diff_clock_input(dref));
  scs_top #(.SETTLE_CYCLES(20)) DUT (.clk(clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .por_mode_strap(strap), .cfg_select_low(sel_lo),
    .cfg_select_high(sel_hi), .input_source_pin(src_pin),
    .crystal_ref_input(xref), .diff_clock_input(dref),
    .ref_clk_out(ref_clk_out), .div_out(div_out), .div_sync(div_sync),
    .hw_select_mode(hw_select_mode), .active_config(active_config),
    .config_busy(config_busy), .ref_on_crystal(ref_on_crystal),
    .crystal_cap_code(crystal_cap_code),
    .xin_cap_half_pf(xin_cap_half_pf), .xout_cap_half_pf(xout_cap_half_pf));
  // ==========================================================
  // Bus and wait helpers
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // Waits for a load to start and finish, counting sync pulses
  task automatic settle();
    syncs = 0;
    while (config_busy !== 1'b1) begin
      @(posedge clk);
    end
    while (config_busy !== 1'b0) begin
      @(posedge clk);
      if (div_sync === 1'b1) syncs++;
    end
  endtask : settle
  task automatic do_reset(input logic s, input logic [1:0] c);
    strap_req <= s;
    sel_req <= c;
    rst <= 1'b1;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    settle();
  endtask : do_reset
  task automatic report_and_stop();
    if (n_fail == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : report_and_stop
  // ==========================================================
  // Scenarios
  task automatic t_soft();
    `CHK(hw_select_mode, 1'b0)
    apb(1'b0, scs_pkg::A_CTRL, 32'h0);
    `CHK(rd[scs_pkg::CTRL_DEF_BIT], scs_pkg::CTRL_DEF_RST)
    apb(1'b0, 8'h40, 32'h0);
    `CHK(rd[11:0], scs_pkg::SWDEF_INT_RST[0])
    apb(1'b1, scs_pkg::A_CTRL, 32'h00000002);
    settle();
    apb(1'b0, 8'h40, 32'h0);
    `CHK(rd[11:0], scs_pkg::CFG_INT_RST[0][0])
    apb(1'b1, scs_pkg::A_CAP, 32'h00000B0B);
    `CHK(er, 1'b0)
    @(posedge clk);
    `CHK(crystal_cap_code, 6'h0B)
    `CHK(xin_cap_half_pf, 7'h1D)
    `CHK(xout_cap_half_pf, 7'h1D)
    apb(1'b0, 8'h30, 32'h0);
    `CHK(er, 1'b1)
    strap_req <= 1'b1;
    repeat (8) @(posedge clk);
    `CHK(hw_select_mode, 1'b0)
  endtask : t_soft
  // Walks source bit and pin one change at a time
  task automatic t_ref();
    int g;
    int n;
    for (int i = 0; i < 4; i++) begin
      g = i ^ (i >> 1);
      apb(1'b1, scs_pkg::A_REF, {30'h0, g[1], 1'b0});
      src_req <= g[0];
      n = 0;
      while (ref_on_crystal !== (g[1] == g[0]) && n < 80) begin
        @(posedge clk);
        n++;
      end
      `CHK(ref_on_crystal, g[1] == g[0])
    end
    apb(1'b1, scs_pkg::A_REF, 32'h0000000A);
    src_req <= 1'b1;
    repeat (40) @(posedge clk);
    `CHK(ref_on_crystal, 1'b0)
  endtask : t_ref
  task automatic t_bypass();
    logic prev;
    apb(1'b1, 8'h40, 32'h00020004);
    repeat (3) @(posedge clk);
    prev = ref_clk_out;
    repeat (24) begin
      @(posedge clk);
      `CHK(div_out[0], prev)
      prev = ref_clk_out;
    end
  endtask : t_bypass
  // Manual sync, spread readback, cascade ratio of divider 1
  task automatic t_div();
    int r0;
    int r1;
    logic [3:0] pv;
    apb(1'b1, scs_pkg::A_CTRL, 32'h00000001);
    @(posedge clk);
    `CHK(div_sync, 1'b1)
    apb(1'b1, 8'h50, 32'h00040004);
    apb(1'b1, 8'h68, 32'h00000400);
    apb(1'b1, 8'h6C, 32'h00000002);
    apb(1'b1, 8'h60, 32'h00080008);
    apb(1'b0, 8'h68, 32'h0);
    `CHK(rd[23:0], 24'h000400)
    r0 = 0;
    r1 = 0;
    pv = div_out;
    while (r1 < 2) begin
      @(posedge clk);
      if (r1 == 1 && div_out[0] && !pv[0]) r0++;
      if (div_out[1] && !pv[1]) r1++;
      pv = div_out;
    end
    `CHK(r0, 4)
  endtask : t_div
  task automatic t_hw();
    do_reset(1'b1, 2'h2);
    `CHK(hw_select_mode, 1'b1)
    `CHK(active_config, 2'h2)
    `CHK(syncs, 1)
    apb(1'b1, scs_pkg::A_REF, 32'h00000002);
    `CHK(er, 1'b1)
    sel_req <= 2'h3;
    settle();
    `CHK(active_config, 2'h3)
    `CHK(syncs, 1)
    sel_req <= 2'h0;
    settle();
    `CHK(active_config, 2'h2)
    settle();
    `CHK(active_config, 2'h0)
  endtask : t_hw
  initial begin
    do_reset(1'b0, 2'h3);
    t_soft();
    t_ref();
    t_bypass();
    t_div();
    t_hw();
    report_and_stop();
  end
  initial begin
    #100000;
    n_fail++;
    report_and_stop();
  end
endmodule : scs_tb_top
`default_nettype wire

// [rtl/scs_fdiv.sv]
// Fractional output divider with spread, bypass and a sync clear.
// Assumes source edges arrive as one-cycle ticks on the same clock.
`timescale 1ns/100ps
`default_nettype none
module scs_fdiv #(
  parameter int INT_W = 12,
  parameter int FRAC_W = 24,
  parameter int RATE_W = 16,
  parameter int TRI_SHIFT = 5
) (
  input wire logic clk, // Clock
  input wire logic rst, // Synchronous reset
  input wire logic src_tick, // Source rising edge
  input wire logic src_level, // Source level
  input wire logic sync_rst, // Alignment clear
  input wire logic [INT_W-1:0] int_div, // Integer ratio
  input wire logic [FRAC_W-1:0] frac, // Fractional ratio
  input wire logic frac_en, // Fractional mode
  input wire logic bypass, // Divide by one
  input wire logic ss_en, // Spread enable
  input wire logic ss_down, // Down spread
  input wire logic [FRAC_W-1:0] ss_amp, // Spread peak
  input wire logic [RATE_W-1:0] ss_rate, // Cycles per step, less one
  output logic out_level, // Divided output
  output logic out_tick // Output rising edge
);
  typedef struct packed {
    logic [INT_W:0] cnt;
    logic [INT_W:0] period;
    logic [FRAC_W-1:0] acc;
    logic [FRAC_W-1:0] tri_v;
    logic tri_dn;
    logic [RATE_W-1:0] rcnt;
    logic out;
    logic prev;
  } scs_fdiv_state_t;

  scs_fdiv_state_t q, n;
  logic [INT_W:0] lim, cnt_inc;
  logic [FRAC_W-1:0] mods, fr, step;
  logic [FRAC_W:0] sum;

  assign lim = (int_div < INT_W'(2)) ? (INT_W+1)'(2) : {1'b0, int_div};
  assign cnt_inc = q.cnt + {{INT_W{1'b0}}, 1'b1};
  assign step = ss_amp >> TRI_SHIFT;
  assign mods = !ss_en ? '0 : (ss_down ? q.tri_v : q.tri_v - (ss_amp >> 1));
  assign fr = frac_en ? frac + mods : '0;
  assign sum = {1'b0, q.acc} + {1'b0, fr};

  always_comb begin
    n = q;
    n.prev = q.out;
    // Triangle modulation, one step every ss_rate+1 cycles
    if (!ss_en) begin
      n.tri_v = '0;
      n.tri_dn = 1'b0;
      n.rcnt = '0;
    end else if (q.rcnt >= ss_rate) begin
      n.rcnt = '0;
      if (!q.tri_dn) begin
        if ({1'b0, q.tri_v} + {1'b0, step} >= {1'b0, ss_amp}) begin
          n.tri_v = ss_amp;
          n.tri_dn = 1'b1;
        end else begin
          n.tri_v = q.tri_v + step;
        end
      end else if (q.tri_v <= step) begin
        n.tri_v = '0;
        n.tri_dn = 1'b0;
      end else begin
        n.tri_v = q.tri_v - step;
      end
    end else begin
      n.rcnt = q.rcnt + {{(RATE_W-1){1'b0}}, 1'b1};
    end
    // Period is integer part plus carry of the fraction accumulator
    if (src_tick) begin
      if (cnt_inc >= q.period) begin
        n.cnt = '0;
        n.acc = sum[FRAC_W-1:0];
        n.period = lim + {{INT_W{1'b0}}, sum[FRAC_W]};
      end else begin
        n.cnt = cnt_inc;
      end
    end
    if (sync_rst) begin
      n.cnt = '0;
      n.acc = '0;
      n.period = lim;
      n.tri_v = '0;
      n.tri_dn = 1'b0;
      n.rcnt = '0;
    end
    n.out = bypass ? src_level : (n.cnt < (n.period >> 1));
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      q <= '0;
      q.period <= (INT_W+1)'(2);
    end else begin
      q <= n;
    end
  end

  assign out_level = q.out;
  assign out_tick = q.out & ~q.prev;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  bypass_copy_a: assert property (bypass && !sync_rst |=>
    q.out == $past(src_level))
    else $error("bypass does not copy source");
  int_period_a: assert property (src_tick && !sync_rst && !frac_en &&
    cnt_inc >= q.period |=> q.period == $past(lim) && q.cnt == '0)
    else $error("integer period wrong");
  tri_bound_a: assert property (ss_en && $stable(ss_amp) && q.tri_v <= ss_amp
    |=> q.tri_v <= ss_amp)
    else $error("triangle beyond amplitude");
  sync_clear_a: assert property (sync_rst |=> q.cnt == '0 && q.acc == '0)
    else $error("sync did not clear divider");
endmodule : scs_fdiv
`default_nettype wire

// [rtl/scs_top.sv]
// Package and top of the startup configuration and clock select block.
// Assumes one 100 MHz clock, synchronous active-high reset, an APB master.
//
// Register access over APB and the register offsets were left to the implementer.
package scs_pkg;
  localparam int CLK_PERIOD_NS = 10;
  localparam int SETTLE_TIME_US = 1000;
  localparam int SETTLE_CYC = (SETTLE_TIME_US * 1000 + CLK_PERIOD_NS - 1)
                              / CLK_PERIOD_NS;
  localparam int POR_WAIT = 3;
  localparam int NUM_DIV = 4;
  localparam int NUM_CFG = 4;
  localparam int INT_W = 12;
  localparam int FRAC_W = 24;
  localparam int RATE_W = 16;
  localparam int CODE_W = 6;
  localparam int TRI_SHIFT = 5;
  // Register byte offsets, divider block top address bits and word selects
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_STATUS = 8'h04;
  localparam logic [7:0] A_REF = 8'h08;
  localparam logic [7:0] A_CAP = 8'h0C;
  localparam logic [1:0] A_DIV_TOP = 2'h1;
  localparam logic [1:0] D_CTL = 2'h0;
  localparam logic [1:0] D_FRAC = 2'h1;
  localparam logic [1:0] D_AMP = 2'h2;
  localparam logic [1:0] D_RATE = 2'h3;
  // Field positions
  localparam int CTRL_SYNC_BIT = 0;
  localparam int CTRL_RELOAD_BIT = 1;
  localparam int CTRL_DEF_BIT = 7;
  localparam int REF_PRIM_BIT = 1;
  localparam int REF_SM_LSB = 2;
  localparam int CAP_XOUT_LSB = 8;
  localparam int DC_FRAC_EN = 16;
  localparam int DC_BYPASS = 17;
  localparam int DC_CASCADE = 18;
  localparam int DC_SS_EN = 19;
  localparam int DC_SS_DOWN = 20;
  localparam int DC_W = 21;
  // Synchroniser bit positions
  localparam int SY_STRAP = 0;
  localparam int SY_SEL0 = 1;
  localparam int SY_CFG_SELECT_HIGH = 2;
  localparam int SY_INPUT_SOURCE_PIN = 3;
  localparam int SY_XTAL = 4;
  localparam int SY_DIFF = 5;
  // Reset values
  localparam logic CTRL_DEF_RST = 1'b1;
  localparam logic REF_PRIM_RST = 1'b0;
  localparam logic [1:0] SM_RST = 2'h0;
  localparam logic [5:0] CAP_RST = 6'h00;
  localparam logic [6:0] CAP_BASE_HALF_PF = 7'h12;
  localparam logic [15:0] RATE_RST = 16'h0030;
  typedef logic [NUM_DIV-1:0][INT_W-1:0] scs_divset_t;
  typedef scs_divset_t [NUM_CFG-1:0] scs_cfgset_t;
  // Stored configuration images, plain defaults
  localparam scs_cfgset_t CFG_INT_RST = {
    {12'h020, 12'h010, 12'h008, 12'h004},
    {12'h018, 12'h00C, 12'h006, 12'h003},
    {12'h010, 12'h008, 12'h004, 12'h002},
    {12'h008, 12'h006, 12'h004, 12'h002}};
  localparam scs_divset_t SWDEF_INT_RST = {12'h00A, 12'h00A, 12'h005, 12'h005};
  typedef enum logic [1:0] {ST_POR, ST_LOAD, ST_SETTLE, ST_RUN} scs_state_t;
  typedef enum logic [1:0] {RF_RUN, RF_GATE, RF_SWAP} scs_ref_t;
endpackage : scs_pkg

`timescale 1ns/100ps
`default_nettype none
module scs_top #(
  parameter int SETTLE_CYCLES = scs_pkg::SETTLE_CYC,
  parameter scs_pkg::scs_cfgset_t CFG_INT = scs_pkg::CFG_INT_RST,
  parameter scs_pkg::scs_divset_t SWDEF_INT = scs_pkg::SWDEF_INT_RST
) (
  input wire logic clk, // 100 MHz clock
  input wire logic rst, // Synchronous reset
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB write
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error
  input wire logic por_mode_strap, // Mode strap pin
  input wire logic cfg_select_low, // Config select LSB pin
  input wire logic cfg_select_high, // Config select MSB pin
  input wire logic input_source_pin, // Reference select pin
  input wire logic crystal_ref_input, // Crystal reference level
  input wire logic diff_clock_input, // Differential reference level
  output logic ref_clk_out, // Selected reference
  output logic [3:0] div_out, // Divider outputs
  output logic div_sync, // Divider sync pulse
  output logic hw_select_mode, // Mode held since reset
  output logic [1:0] active_config, // Config select index sampled from the pins
  output logic config_busy, // Startup wait, loading or settling
  output logic ref_on_crystal, // Crystal is current source
  output logic [5:0] crystal_cap_code, // XIN cap code
  output logic [6:0] xin_cap_half_pf, // XIN cap, 0.5 pF units
  output logic [6:0] xout_cap_half_pf // XOUT cap, 0.5 pF units
);
  typedef struct packed {
    logic [5:0] s1;
    logic [5:0] s2;
    scs_pkg::scs_state_t st;
    logic [31:0] cnt;
    logic hw_mode;
    logic [1:0] sel_act;
    logic sync_pls;
    logic reload_req;
    logic load_def;
    logic prim;
    logic [1:0] sm;
    logic [5:0] cap_xin;
    logic [5:0] cap_xout;
    logic [6:0] pf_xin;
    logic [6:0] pf_xout;
    logic [3:0][scs_pkg::DC_W-1:0] dctl;
    logic [3:0][23:0] dfrac;
    logic [3:0][23:0] damp;
    logic [3:0][15:0] drate;
    scs_pkg::scs_ref_t rphase;
    logic cur_xtal;
    logic gated;
    logic ref_out;
    logic ref_prev;
    logic [31:0] prdata;
  } scs_top_state_t;

  scs_top_state_t q, n;
  logic mapped, acc, wr, want_xtal, cur_lvl, new_lvl, ref_tick;
  logic [1:0] sel_now, didx;
  logic [3:0] div_lvl, div_tick;

  function automatic logic [31:0] rd_word(input logic [7:0] a);
    logic [31:0] w;
    w = 32'h0000_0000;
    if (a == scs_pkg::A_CTRL) begin
      w[scs_pkg::CTRL_DEF_BIT] = q.load_def;
    end else if (a == scs_pkg::A_STATUS) begin
      w[5:0] = {q.rphase != scs_pkg::RF_RUN, q.cur_xtal,
                q.st != scs_pkg::ST_RUN, q.sel_act, q.hw_mode};
    end else if (a == scs_pkg::A_REF) begin
      w[scs_pkg::REF_PRIM_BIT] = q.prim;
      w[scs_pkg::REF_SM_LSB +: 2] = q.sm;
    end else if (a == scs_pkg::A_CAP) begin
      w[5:0] = q.cap_xin;
      w[scs_pkg::CAP_XOUT_LSB +: 6] = q.cap_xout;
    end else if (a[7:6] == scs_pkg::A_DIV_TOP) begin
      case (a[3:2])
        scs_pkg::D_CTL: w[scs_pkg::DC_W-1:0] = q.dctl[a[5:4]];
        scs_pkg::D_FRAC: w[23:0] = q.dfrac[a[5:4]];
        scs_pkg::D_AMP: w[23:0] = q.damp[a[5:4]];
        default: w[15:0] = q.drate[a[5:4]];
      endcase
    end
    return w;
  endfunction : rd_word

  // ==========================================================
  // Bus decode
  assign mapped = (paddr[1:0] == 2'h0) &&
                  (paddr[7:4] == 4'h0 || paddr[7:6] == scs_pkg::A_DIV_TOP);
  assign acc = psel & penable;
  assign pready = 1'b1;
  assign pslverr = acc & (q.hw_mode | q.st == scs_pkg::ST_POR | ~mapped);
  assign wr = acc & pwrite & ~pslverr;
  assign didx = paddr[5:4];
  assign sel_now = {q.s2[scs_pkg::SY_CFG_SELECT_HIGH], q.s2[scs_pkg::SY_SEL0]};

  // ==========================================================
  // Reference selection
  assign want_xtal = (q.sm[1] == 1'b0) ?
                     (q.prim == q.s2[scs_pkg::SY_INPUT_SOURCE_PIN]) : q.cur_xtal;
  assign cur_lvl = q.cur_xtal ? q.s2[scs_pkg::SY_XTAL] : q.s2[scs_pkg::SY_DIFF];
  assign new_lvl = q.cur_xtal ? q.s2[scs_pkg::SY_DIFF] : q.s2[scs_pkg::SY_XTAL];
  assign ref_tick = q.ref_out & ~q.ref_prev;

  always_comb begin
    n = q;
    n.s1 = {diff_clock_input, crystal_ref_input, input_source_pin,
            cfg_select_high, cfg_select_low, por_mode_strap};
    n.s2 = q.s1;
    n.sync_pls = 1'b0;
    n.ref_prev = q.ref_out;
    if (psel & ~penable) begin
      n.prdata = rd_word(paddr);
    end
    if (wr) begin
      if (paddr == scs_pkg::A_CTRL) begin
        n.load_def = pwdata[scs_pkg::CTRL_DEF_BIT];
        n.sync_pls = pwdata[scs_pkg::CTRL_SYNC_BIT];
        n.reload_req = pwdata[scs_pkg::CTRL_RELOAD_BIT];
      end else if (paddr == scs_pkg::A_REF) begin
        n.prim = pwdata[scs_pkg::REF_PRIM_BIT];
        n.sm = pwdata[scs_pkg::REF_SM_LSB +: 2];
      end else if (paddr == scs_pkg::A_CAP) begin
        n.cap_xin = pwdata[5:0];
        n.cap_xout = pwdata[scs_pkg::CAP_XOUT_LSB +: 6];
      end else if (paddr[7:6] == scs_pkg::A_DIV_TOP) begin
        case (paddr[3:2])
          scs_pkg::D_CTL: n.dctl[didx] = pwdata[scs_pkg::DC_W-1:0];
          scs_pkg::D_FRAC: n.dfrac[didx] = pwdata[23:0];
          scs_pkg::D_AMP: n.damp[didx] = pwdata[23:0];
          default: n.drate[didx] = pwdata[15:0];
        endcase
      end
    end
    n.pf_xin = scs_pkg::CAP_BASE_HALF_PF + {1'b0, n.cap_xin};
    n.pf_xout = scs_pkg::CAP_BASE_HALF_PF + {1'b0, n.cap_xout};
    // Startup and configuration load
    case (q.st)
      scs_pkg::ST_POR: begin
        n.cnt = q.cnt + 32'h0000_0001;
        if (q.cnt == 32'(scs_pkg::POR_WAIT - 1)) begin
          n.hw_mode = q.s2[scs_pkg::SY_STRAP];
          n.sel_act = sel_now;
          n.st = scs_pkg::ST_LOAD;
        end
      end
      scs_pkg::ST_LOAD: begin
        for (int i = 0; i < scs_pkg::NUM_DIV; i++) begin
          n.dctl[i] = '0;
          n.dfrac[i] = '0;
          n.damp[i] = '0;
          n.drate[i] = scs_pkg::RATE_RST;
          if (q.hw_mode) begin
            n.dctl[i][11:0] = CFG_INT[q.sel_act][i];
          end else if (q.load_def) begin
            n.dctl[i][11:0] = SWDEF_INT[i];
          end else begin
            n.dctl[i][11:0] = CFG_INT[0][i];
          end
        end
        n.sync_pls = q.hw_mode | n.sync_pls;
        n.reload_req = 1'b0;
        n.cnt = '0;
        n.st = scs_pkg::ST_SETTLE;
      end
      scs_pkg::ST_SETTLE: begin
        n.cnt = q.cnt + 32'h0000_0001;
        if (q.cnt >= 32'(SETTLE_CYCLES - 1)) begin
          n.st = scs_pkg::ST_RUN;
        end
      end
      scs_pkg::ST_RUN: begin
        if (q.hw_mode && sel_now != q.sel_act) begin
          n.sel_act = sel_now;
          n.st = scs_pkg::ST_LOAD;
        end else if (q.reload_req) begin
          n.st = scs_pkg::ST_LOAD;
        end
      end
      default: n.st = scs_pkg::ST_POR;
    endcase
    // Glitch-free switch: park low on old source, take new one while low
    case (q.rphase)
      scs_pkg::RF_RUN: begin
        if (want_xtal != q.cur_xtal) begin
          n.rphase = scs_pkg::RF_GATE;
        end
      end
      scs_pkg::RF_GATE: begin
        if (!cur_lvl) begin
          n.gated = 1'b1;
          n.rphase = scs_pkg::RF_SWAP;
        end
      end
      scs_pkg::RF_SWAP: begin
        if (!new_lvl) begin
          n.cur_xtal = ~q.cur_xtal;
          n.gated = 1'b0;
          n.rphase = scs_pkg::RF_RUN;
        end
      end
      default: n.rphase = scs_pkg::RF_RUN;
    endcase
    n.ref_out = n.gated ? 1'b0 : (n.cur_xtal ? q.s2[scs_pkg::SY_XTAL]
                                             : q.s2[scs_pkg::SY_DIFF]);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      q <= '0;
      q.st <= scs_pkg::ST_POR;
      q.load_def <= scs_pkg::CTRL_DEF_RST;
      q.prim <= scs_pkg::REF_PRIM_RST;
      q.sm <= scs_pkg::SM_RST;
      q.cap_xin <= scs_pkg::CAP_RST;
      q.cap_xout <= scs_pkg::CAP_RST;
      q.pf_xin <= scs_pkg::CAP_BASE_HALF_PF;
      q.pf_xout <= scs_pkg::CAP_BASE_HALF_PF;
      q.rphase <= scs_pkg::RF_RUN;
      q.cur_xtal <= 1'b1;
    end else begin
      q <= n;
    end
  end

  // ==========================================================
  // Dividers 1 to 3 may each cascade from their lower neighbour
  for (genvar g = 0; g < scs_pkg::NUM_DIV; g++) begin : g_div
    localparam int P = (g == 0) ? 0 : g - 1;
    logic casc;
    assign casc = (g != 0) && q.dctl[g][scs_pkg::DC_CASCADE];
    scs_fdiv u_div (
      .clk(clk),
      .rst(rst),
      .src_tick(casc ? div_tick[P] : ref_tick),
      .src_level(casc ? div_lvl[P] : q.ref_out),
      .sync_rst(q.sync_pls),
      .int_div(q.dctl[g][11:0]),
      .frac(q.dfrac[g]),
      .frac_en(q.dctl[g][scs_pkg::DC_FRAC_EN]),
      .bypass(q.dctl[g][scs_pkg::DC_BYPASS]),
      .ss_en(q.dctl[g][scs_pkg::DC_SS_EN]),
      .ss_down(q.dctl[g][scs_pkg::DC_SS_DOWN]),
      .ss_amp(q.damp[g]),
      .ss_rate(q.drate[g]),
      .out_level(div_lvl[g]),
      .out_tick(div_tick[g])
    );
  end

  assign prdata = q.prdata;
  assign ref_clk_out = q.ref_out;
  assign div_out = div_lvl;
  assign div_sync = q.sync_pls;
  assign hw_select_mode = q.hw_mode;
  assign active_config = q.sel_act;
  assign config_busy = q.st != scs_pkg::ST_RUN;
  assign ref_on_crystal = q.cur_xtal;
  assign crystal_cap_code = q.cap_xin;
  assign xin_cap_half_pf = q.pf_xin;
  assign xout_cap_half_pf = q.pf_xout;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence sel_moved;
    q.st == scs_pkg::ST_RUN && q.hw_mode && sel_now != q.sel_act;
  endsequence
  sequence reload_run;
    q.st == scs_pkg::ST_LOAD ##1 q.st == scs_pkg::ST_SETTLE && q.sync_pls;
  endsequence

  mode_capture_a: assert property (q.st == scs_pkg::ST_POR &&
    q.cnt == 32'(scs_pkg::POR_WAIT - 1) |=> q.hw_mode == $past(q.s2[0]))
    else $error("mode not taken from strap");
  mode_hold_a: assert property (q.st != scs_pkg::ST_POR |=> $stable(q.hw_mode))
    else $error("mode changed after startup");
  bus_deny_a: assert property (acc && q.hw_mode |-> pslverr && !wr)
    else $error("bus open in hardware mode");
  sw_write_a: assert property (acc && pwrite && !q.hw_mode &&
    q.st != scs_pkg::ST_POR && paddr == scs_pkg::A_CAP |=>
    q.cap_xin == $past(pwdata[5:0]))
    else $error("software write lost");
  sel_reload_a: assert property (sel_moved |=> reload_run)
    else $error("select change did not reload and sync");
  cfg_load_a: assert property (q.st == scs_pkg::ST_LOAD && q.hw_mode |=>
    q.dctl[1][11:0] == CFG_INT[q.sel_act][1])
    else $error("wrong stored config loaded");
  sw_default_a: assert property (q.st == scs_pkg::ST_LOAD && !q.hw_mode |=>
    q.dctl[0][11:0] == ($past(q.load_def) ? SWDEF_INT[0] : CFG_INT[0][0]))
    else $error("wrong software default");
  switch_low_a: assert property ($changed(q.cur_xtal) |-> !q.ref_out ##1
    q.rphase == scs_pkg::RF_RUN)
    else $error("reference switched while high");
  manual_sel_a: assert property (q.rphase == scs_pkg::RF_RUN && !q.sm[1] &&
    want_xtal != q.cur_xtal |=> q.rphase == scs_pkg::RF_GATE)
    else $error("manual switchover not started");
  cap_calc_a: assert property ($changed(q.cap_xin) |->
    q.pf_xin == 7'(18) + {1'b0, q.cap_xin})
    else $error("cap value wrong");
endmodule : scs_top
`default_nettype wire
